// file: src/parity_mon_consts.svh
/*
 * Register indices, field positions and reset values of the DS3 parity
 * error monitor. Assumes it is included by its bare name, once per unit.
 */
`ifndef PARITY_MON_CONSTS_SVH
`define PARITY_MON_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_P_LOW 8'h26
`define IDX_P_HIGH 8'h27
`define IDX_CP_LOW 8'h28
`define IDX_CP_HIGH 8'h29
`define IDX_CTRL 8'h30
`define IDX_STATUS 8'h31
`define IDX_CLEAR 8'h32
`define IDX_ENABLE 8'h33

// Widths
`define ADDR_W 10
`define CNT_W 16
`define EVT_COUNT 2

// Field positions
`define CTRL_COUNT_SYNC_LOST_BIT 0
`define EVT_P_BIT 0
`define EVT_CP_BIT 1

// Reset values
`define COUNT_RESET 16'h0000
`define CTRL_RESET 8'h00
`define EVT_RESET 2'h0

`endif

// file: src/parity_mon_pkg.sv
/*
 * Types shared by the DS3 parity error monitor: framing modes, received
 * bit classes and the APB request and response carriers.
 * Assumes the constants header is on the include path.
 */
`include "parity_mon_consts.svh"

package parity_mon_pkg;

    // Operating mode from the framer core; 2'h2 is not a legal code
    typedef enum logic [1:0] {
        MODE_M23 = 2'h0,
        MODE_CBIT = 2'h1,
        MODE_E3 = 2'h3
    } frame_mode_type;

    // Class of a received bit as marked by the frame aligner
    typedef enum logic [2:0] {
        KIND_OTHER = 3'h0,
        KIND_INFO = 3'h1,
        KIND_P1 = 3'h2,
        KIND_P2 = 3'h3,
        KIND_CP1 = 3'h4,
        KIND_CP2 = 3'h5,
        KIND_CP3 = 3'h6
    } bit_kind_type;

    typedef struct packed {
        logic valid;
        logic value;
        bit_kind_type kind;
        logic frame_end;
    } rx_bit_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

endpackage : parity_mon_pkg

// file: src/parity_tally.sv
/*
 * One error tally: an internal counter and its software-visible latch.
 * Assumes update_i and inc_i are single-cycle strobes on clk_i.
 */
`timescale 1ns/100ps
`include "parity_mon_consts.svh"

module parity_tally #(
    parameter int CNT_W = `CNT_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic inc_i,
    input wire logic update_i,
    output logic [CNT_W-1:0] count_o,
    output logic [CNT_W-1:0] latched_o
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] latched;
    } tally_state_type;

    tally_state_type q;
    tally_state_type d;

    // Latch and restart on update; an error in that same cycle opens the new interval
    always_comb
    begin
        d = q;
        if (update_i)
        begin
            d.latched = q.count;
            d.count = inc_i ? CNT_W'(1) : '0;
        end
        else if (inc_i && (q.count != {CNT_W{1'b1}}))
        begin
            // Saturates rather than wraps, so a long interval never reads small
            d.count = q.count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign count_o = q.count;
    assign latched_o = q.latched;

endmodule : parity_tally

// file: src/parity_accum.sv
/*
 * Running modulo-2 sum over the information bits of each received frame.
 * Assumes frame_end marks the last bit time of a frame, and that a bit
 * presented in that cycle still belongs to the ending frame.
 */
`timescale 1ns/100ps

module parity_accum
    import parity_mon_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input parity_mon_pkg::rx_bit_type rx_bit_i,
    output logic prev_par_o,
    output logic prev_valid_o
);
    typedef struct packed {
        logic run_par;
        logic prev_par;
        logic prev_valid;
    } accum_state_type;

    accum_state_type q;
    accum_state_type d;
    logic par_now;

    // Parity of the frame so far, including an information bit in this cycle
    always_comb
    begin
        d = q;
        par_now = q.run_par ^ (rx_bit_i.valid && (rx_bit_i.kind == KIND_INFO) && rx_bit_i.value);
        if (rx_bit_i.frame_end)
        begin
            // The finished frame's sum is what the next frame's parity bits carry
            d.prev_par = par_now;
            d.prev_valid = 1'b1;
            d.run_par = 1'b0;
        end
        else
        begin
            d.run_par = par_now;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign prev_par_o = q.prev_par;
    assign prev_valid_o = q.prev_valid;

endmodule : parity_accum

// file: src/parity_err_mon.sv
/*
 * DS3 receive parity error monitor: P-bit and CP-bit parity checking,
 * two 16-bit error tallies latched on each counter update, an APB
 * register slave and a level interrupt.
 * Assumes the framer marks every received bit with its class, raises
 * frame_end once per frame, drives the sync-lost level and the mode, and
 * pulses the counter update for one cycle. All inputs are synchronous.
 */
// Functional notes
// - On each update, copy the internal P-parity counter into the readable P count.
// - The P-parity counter adds one per received frame with a P-parity error.
// - In E3 mode the P count means nothing and software ignores it.
// - A frame whose two P bits differ is a P-parity error.
// - P bits disagreeing with the preceding frame's information parity is an error.
// - A control bit picks counting or holding P errors while out of frame.
// - On each update, copy the internal CP-parity counter into the readable CP count.
// - The CP count is meaningful only in C-bit parity DS3 framing.
// - Majority vote of three CP bits against computed parity gives a CP error.
// - The same control bit picks counting or holding CP errors while out of frame.
// - P count reads as low byte at index 26h, high at 27h, reset zero.
// - CP count reads as low byte at index 28h, high at 29h, reset zero.
// - Out of frame means the framer has lost receive frame synchronization.
`timescale 1ns/100ps
`include "parity_mon_consts.svh"

module parity_err_mon
    import parity_mon_pkg::*;
#(
    parameter int CNT_W = `CNT_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input parity_mon_pkg::apb_req_type apb_req_i,
    output parity_mon_pkg::apb_rsp_type apb_rsp_o,
    input parity_mon_pkg::rx_bit_type rx_bit_i,
    input parity_mon_pkg::frame_mode_type frame_mode_i,
    input wire logic frame_sync_lost_i,
    input wire logic counter_update_i,
    output logic irq_o
);
    import parity_mon_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        apb_rsp_type rsp;
        logic [7:0] ctrl;
        logic [`EVT_COUNT-1:0] status;
        logic [`EVT_COUNT-1:0] enable;
        logic irq;
        logic p1;
        logic p2;
        logic [2:0] cp;
    } mon_state_type;

    localparam mon_state_type MON_RESET = '{
        rsp: '0,
        ctrl: `CTRL_RESET,
        status: `EVT_RESET,
        enable: `EVT_RESET,
        irq: 1'b0,
        p1: 1'b0,
        p2: 1'b0,
        cp: 3'h0
    };

    mon_state_type q;
    mon_state_type d;

    logic prev_par;
    logic prev_valid;
    logic [CNT_W-1:0] p_count;
    logic [CNT_W-1:0] p_latched;
    logic [CNT_W-1:0] cp_count;
    logic [CNT_W-1:0] cp_latched;

    logic ds3_mode;
    logic cbit_mode;
    logic count_gate;
    logic frame_eval;
    logic cp_vote;
    logic p_err;
    logic cp_err;
    logic p_inc;
    logic cp_inc;
    logic [7:0] reg_idx;
    logic bus_setup;
    logic bus_access;
    logic wr_take;
    logic [`EVT_COUNT-1:0] evt_set;
    logic [`EVT_COUNT-1:0] evt_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks
    ////////////////////////////////////////////////////////////////////////////

    // Information-bit parity of the frame that ended last
    parity_accum u_accum (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .rx_bit_i(rx_bit_i),
        .prev_par_o(prev_par),
        .prev_valid_o(prev_valid)
    );

    parity_tally #(.CNT_W(CNT_W)) u_p_tally (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(p_inc),
        .update_i(counter_update_i),
        .count_o(p_count),
        .latched_o(p_latched)
    );

    parity_tally #(.CNT_W(CNT_W)) u_cp_tally (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(cp_inc),
        .update_i(counter_update_i),
        .count_o(cp_count),
        .latched_o(cp_latched)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Parity checks, evaluated in the frame_end cycle
    ////////////////////////////////////////////////////////////////////////////

    // Mode decode; the illegal code counts nothing at all
    assign ds3_mode = (frame_mode_i == MODE_M23) || (frame_mode_i == MODE_CBIT);
    assign cbit_mode = (frame_mode_i == MODE_CBIT);

    // Holding while out of frame keeps a resync burst out of the tallies
    assign count_gate = !frame_sync_lost_i ||
                        q.ctrl[`CTRL_COUNT_SYNC_LOST_BIT];

    // No check until one whole frame has been summed since reset
    assign frame_eval = rx_bit_i.frame_end && prev_valid;

    assign cp_vote = (q.cp[0] && q.cp[1]) || (q.cp[0] && q.cp[2]) || (q.cp[1] && q.cp[2]);

    // Parity bits must differ neither from each other nor from the sum
    assign p_err = frame_eval && ds3_mode &&
                   ((q.p1 != q.p2) ||
                    (q.p1 != prev_par) || (q.p2 != prev_par));
    assign cp_err = frame_eval && cbit_mode && (cp_vote != prev_par);

    assign p_inc = p_err && count_gate;
    assign cp_inc = cp_err && count_gate;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    ////////////////////////////////////////////////////////////////////////////

    assign reg_idx = apb_req_i.paddr[`ADDR_W-1:2];
    assign bus_setup = apb_req_i.psel && !apb_req_i.penable;
    assign bus_access = apb_req_i.psel && apb_req_i.penable && q.rsp.pready;
    // Errors are judged at setup, so a refused write never lands
    assign wr_take = bus_access && apb_req_i.pwrite && !q.rsp.pslverr && apb_req_i.pstrb[0];

    assign evt_set = {cp_err, p_err};
    assign evt_clr = (wr_take && (reg_idx == `IDX_CLEAR)) ?
                     apb_req_i.pwdata[`EVT_COUNT-1:0] : `EVT_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        d = q;

        // Capture the overhead bits of the current frame as they pass
        if (rx_bit_i.valid)
        begin
            unique case (rx_bit_i.kind)
                KIND_OTHER, KIND_INFO: d.p1 = q.p1;
                KIND_P1: d.p1 = rx_bit_i.value;
                KIND_P2: d.p2 = rx_bit_i.value;
                KIND_CP1: d.cp[0] = rx_bit_i.value;
                KIND_CP2: d.cp[1] = rx_bit_i.value;
                KIND_CP3: d.cp[2] = rx_bit_i.value;
                default: d.p1 = q.p1;
            endcase
        end

        // Zero wait states: ready rises in the access cycle, for one cycle
        d.rsp.pready = 1'b0;
        if (bus_setup)
        begin
            d.rsp.pready = 1'b1;
            d.rsp.pslverr = 1'b0;
            d.rsp.prdata = 32'h0000_0000;
            if (apb_req_i.paddr[1:0] != 2'h0)
            begin
                d.rsp.pslverr = 1'b1;
            end
            else if (apb_req_i.pwrite)
            begin
                // Only control, clear and enable take writes
                d.rsp.pslverr = !((reg_idx == `IDX_CTRL) || (reg_idx == `IDX_CLEAR) ||
                                  (reg_idx == `IDX_ENABLE));
            end
            else
            begin
                unique case (reg_idx)
                    `IDX_P_LOW: d.rsp.prdata = {24'h00_0000, p_latched[7:0]};
                    `IDX_P_HIGH: d.rsp.prdata = {24'h00_0000, p_latched[15:8]};
                    `IDX_CP_LOW: d.rsp.prdata = {24'h00_0000, cp_latched[7:0]};
                    `IDX_CP_HIGH: d.rsp.prdata = {24'h00_0000, cp_latched[15:8]};
                    `IDX_CTRL: d.rsp.prdata = {24'h00_0000, q.ctrl};
                    `IDX_STATUS: d.rsp.prdata = {30'h0000_0000, q.status};
                    `IDX_CLEAR: d.rsp.prdata = 32'h0000_0000;
                    `IDX_ENABLE: d.rsp.prdata = {30'h0000_0000, q.enable};
                    default: d.rsp.pslverr = 1'b1;
                endcase
            end
        end

        // Register writes take effect on the access edge only
        if (wr_take && (reg_idx == `IDX_CTRL))
        begin
            d.ctrl = {7'h00, apb_req_i.pwdata[`CTRL_COUNT_SYNC_LOST_BIT]};
        end
        if (wr_take && (reg_idx == `IDX_ENABLE))
        begin
            d.enable = apb_req_i.pwdata[`EVT_COUNT-1:0];
        end

        // Sticky events; a detection in the clearing cycle survives
        d.status = (q.status & ~evt_clr) | evt_set;

        // Interrupt follows the registered status, so it comes from a flop
        d.irq = |(d.status & d.enable);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            q <= MON_RESET;
        else
            q <= d;
    end

    assign apb_rsp_o = q.rsp;
    assign irq_o = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////

    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_read_setup(logic [7:0] idx);
        apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite &&
        (apb_req_i.paddr[1:0] == 2'h0) && (apb_req_i.paddr[`ADDR_W-1:2] == idx);
    endsequence

    sequence s_frame_check;
        rx_bit_i.frame_end && prev_valid;
    endsequence

    chk_p_latch_copy:
        assert property (counter_update_i |=> (p_latched == $past(p_count)))
        else $error("P count not latched on update");

    chk_cp_latch_copy:
        assert property (counter_update_i |=> (cp_latched == $past(cp_count)))
        else $error("CP count not latched on update");

    chk_p_count_step:
        assert property ((p_inc && !counter_update_i && (p_count != 16'hffff))
                         |=> (p_count == $past(p_count) + 16'h0001))
        else $error("P counter did not step by one");

    chk_p_pair_differ:
        assert property ((s_frame_check and (ds3_mode && (q.p1 != q.p2)))
                         |=> q.status[`EVT_P_BIT])
        else $error("Differing P bits not flagged");

    chk_p_vs_parity:
        assert property ((s_frame_check and (ds3_mode && (q.p1 == q.p2) && (q.p1 != prev_par)))
                         |=> q.status[`EVT_P_BIT])
        else $error("P bits against frame parity not flagged");

    chk_sync_hold:
        assert property ((frame_sync_lost_i && !q.ctrl[`CTRL_COUNT_SYNC_LOST_BIT] &&
                          !counter_update_i) |=> ($stable(p_count) && $stable(cp_count)))
        else $error("Counter moved while held out of frame");

    chk_e3_quiet:
        assert property (((frame_mode_i == MODE_E3) && !counter_update_i)
                         |=> ($stable(p_count) && $stable(cp_count)))
        else $error("Counter moved in E3 mode");

    chk_cp_vote:
        assert property ((s_frame_check and (cbit_mode &&
                          (((q.cp[0] + q.cp[1] + q.cp[2]) >= 2'h2) != prev_par)))
                         |=> q.status[`EVT_CP_BIT])
        else $error("CP majority mismatch not flagged");

    chk_restart_zero:
        assert property ((counter_update_i && !p_inc && !cp_inc)
                         |=> ((p_count == 16'h0000) && (cp_count == 16'h0000)))
        else $error("Counter did not restart after update");

    chk_read_p_high:
        assert property (s_read_setup(`IDX_P_HIGH)
                         |=> (apb_rsp_o.pready && !apb_rsp_o.pslverr &&
                              (apb_rsp_o.prdata == ({16'h0000, $past(p_latched)} >> 8))))
        else $error("P high byte read wrong");

    chk_read_cp_low:
        assert property (s_read_setup(`IDX_CP_LOW)
                         |=> (apb_rsp_o.pready &&
                              (apb_rsp_o.prdata == {24'h00_0000, $past(cp_latched[7:0])})))
        else $error("CP low byte read wrong");

    chk_read_p_low:
        assert property (s_read_setup(`IDX_P_LOW)
                         |=> (apb_rsp_o.pready && !apb_rsp_o.pslverr &&
                              (apb_rsp_o.prdata == {24'h00_0000, $past(p_latched[7:0])})))
        else $error("P low byte read wrong");

    chk_read_cp_high:
        assert property (s_read_setup(`IDX_CP_HIGH)
                         |=> (apb_rsp_o.pready && !apb_rsp_o.pslverr &&
                              (apb_rsp_o.prdata == {24'h00_0000, $past(cp_latched[15:8])})))
        else $error("CP high byte read wrong");

    chk_cp_count_step:
        assert property ((cp_inc && !counter_update_i && (cp_count != 16'hffff))
                         |=> (cp_count == $past(cp_count) + 16'h0001))
        else $error("CP counter did not step by one");

    chk_m23_cp_quiet:
        assert property (((frame_mode_i == MODE_M23) && !counter_update_i)
                         |=> $stable(cp_count))
        else $error("CP counter moved in M23 mode");

    chk_irq_level:
        assert property (irq_o == |(q.status & q.enable))
        else $error("Interrupt does not follow enabled status");

endmodule : parity_err_mon

// file: bench/tb_top.sv
/*
 * Self-checking bench of the DS3 parity error monitor: APB register
 * reads and writes, framed receive bits with chosen and random parity
 * faults, counter updates, sync-loss gating, modes and the interrupt.
 * Assumes the design package and constants header are on the path.
 */
`timescale 1ns/100ps
`include "parity_mon_consts.svh"

module tb_top;
    import parity_mon_pkg::*;

    logic clk_i;
    logic sys_rst_i;
    apb_req_type apb_req;
    apb_rsp_type apb_rsp;
    rx_bit_type rx_bit;
    frame_mode_type frame_mode;
    logic sync_lost;
    logic counter_update;
    logic irq;
    int error_cnt;
    int total_checks;
    logic prev_par;
    logic have_prev;
    logic ctrl_count;
    logic [1:0] exp_st;
    logic [1:0] irq_en;
    logic [15:0] exp_p;
    logic [15:0] exp_cp;
    logic [15:0] lat_p;
    logic [15:0] lat_cp;
    frame_mode_type modes[4] = '{MODE_M23, MODE_E3, MODE_CBIT, frame_mode_type'(2'h2)};
    logic [7:0] idxs[8] = '{`IDX_P_LOW, `IDX_P_HIGH, `IDX_CP_LOW, `IDX_CP_HIGH,
                            `IDX_CTRL, `IDX_STATUS, `IDX_CLEAR, `IDX_ENABLE};

    parity_err_mon #(.CNT_W(16)) dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .apb_req_i(apb_req),
        .apb_rsp_o(apb_rsp),
        .rx_bit_i(rx_bit),
        .frame_mode_i(frame_mode),
        .frame_sync_lost_i(sync_lost),
        .counter_update_i(counter_update),
        .irq_o(irq)
    );

    // 40 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task tally_and_finish();
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task check_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag

    // One APB transfer; pready is sampled at rising edges, as the slave sees them
    task apb_xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                  output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= wd;
        apb_req.pstrb <= 4'hf;
        @(posedge clk_i);
        apb_req.penable <= 1'b1;
        // Wait states are the slave's choice; only the watchdog ends a hang
        @(posedge clk_i);
        while (apb_rsp.pready !== 1'b1)
            @(posedge clk_i);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb_xfer

    task rd_chk(input logic [9:0] a, input logic [31:0] exp, input logic exp_err,
                input string what);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, a, 32'h0, rd, err);
        check_word(what, exp, rd);
        check_flag({what, " slave error"}, exp_err, err);
    endtask : rd_chk

    task wr_chk(input logic [9:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, a, d, rd, err);
        check_flag("write slave error", exp_err, err);
    endtask : wr_chk

    ////////////////////////////////////////////////////////////////////////
    task put_bit(input bit_kind_type k, input logic v, input logic fe);
        @(posedge clk_i);
        rx_bit <= '{valid: 1'b1, value: v, kind: k, frame_end: fe};
    endtask : put_bit

    // Expected {CP, P} error flags of a checked frame with the given bit flips
    function automatic logic [1:0] frame_errs(input logic pa, input logic pb,
                                              input logic [2:0] cf, input frame_mode_type md);
        logic maj;
        maj = (cf[0] & cf[1]) | (cf[0] & cf[2]) | (cf[1] & cf[2]);
        return {maj && (md == MODE_CBIT), (pa | pb) && (md == MODE_M23 || md == MODE_CBIT)};
    endfunction : frame_errs

    // Frame with P and CP bits flipped against the previous frame's parity
    task send_frame(input logic pa, input logic pb, input logic [2:0] cf);
        int len;
        logic par;
        logic v;
        logic pe;
        logic ce;
        len = 4 + $urandom_range(16);
        par = 1'b0;
        put_bit(KIND_P1, prev_par ^ pa, 1'b0);
        put_bit(KIND_P2, prev_par ^ pb, 1'b0);
        put_bit(KIND_CP1, prev_par ^ cf[0], 1'b0);
        put_bit(KIND_CP2, prev_par ^ cf[1], 1'b0);
        put_bit(KIND_CP3, prev_par ^ cf[2], 1'b0);
        for (int i = 0; i < len; i++)
        begin
            v = 1'($urandom_range(1));
            par ^= v;
            put_bit(KIND_INFO, v, 1'b0);
        end
        put_bit(KIND_OTHER, 1'b0, 1'b1);
        @(posedge clk_i);
        rx_bit <= '0;
        // Mismatch of either P bit; majority of CP bits wrong
        {ce, pe} = have_prev ? frame_errs(pa, pb, cf, frame_mode) : 2'b00;
        if (pe && (!sync_lost || ctrl_count))
            exp_p++;
        if (ce && (!sync_lost || ctrl_count))
            exp_cp++;
        exp_st |= {ce, pe};
        prev_par = par;
        have_prev = 1'b1;
        @(negedge clk_i);
        check_flag("irq", |(exp_st & irq_en), irq);
    endtask : send_frame

    task do_update();
        @(posedge clk_i);
        counter_update <= 1'b1;
        @(posedge clk_i);
        counter_update <= 1'b0;
        lat_p = exp_p;
        lat_cp = exp_cp;
        exp_p = '0;
        exp_cp = '0;
    endtask : do_update

    task check_counts();
        rd_chk({`IDX_P_LOW, 2'b00}, {24'h0, lat_p[7:0]}, 1'b0, "p low");
        rd_chk({`IDX_P_HIGH, 2'b00}, {24'h0, lat_p[15:8]}, 1'b0, "p high");
        rd_chk({`IDX_CP_LOW, 2'b00}, {24'h0, lat_cp[7:0]}, 1'b0, "cp low");
        rd_chk({`IDX_CP_HIGH, 2'b00}, {24'h0, lat_cp[15:8]}, 1'b0, "cp high");
    endtask : check_counts

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the few thousand cycles the tests need
    initial
    begin
        repeat (50000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        error_cnt = 0;
        total_checks = 0;
        apb_req = '0;
        rx_bit = '0;
        frame_mode = MODE_CBIT;
        sync_lost = 1'b0;
        counter_update = 1'b0;
        prev_par = 1'b0;
        have_prev = 1'b0;
        ctrl_count = 1'b0;
        exp_st = '0;
        irq_en = '0;
        exp_p = '0;
        exp_cp = '0;
        void'($urandom(16071));
        sys_rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (idxs[i])
            rd_chk({idxs[i], 2'b00}, 32'h0, 1'b0, "reset value");
        // Refusals: unmapped, misaligned, write to a read-only count
        rd_chk(10'h0fc, 32'h0, 1'b1, "unmapped read");
        rd_chk({`IDX_P_LOW, 2'b01}, 32'h0, 1'b1, "misaligned read");
        wr_chk({`IDX_P_HIGH, 2'b00}, 32'h55, 1'b1);
        wr_chk({`IDX_ENABLE, 2'b00}, 32'h3, 1'b0);
        irq_en = 2'h3;
        // First frame has no predecessor, so its faults are not counted
        send_frame(1'b1, 1'b0, 3'b011);
        send_frame(1'b1, 1'b0, 3'b000);
        send_frame(1'b1, 1'b1, 3'b000);
        send_frame(1'b0, 1'b0, 3'b100);
        send_frame(1'b0, 1'b0, 3'b101);
        send_frame(1'b0, 1'b0, 3'b111);
        repeat (30)
            send_frame(1'($urandom_range(1)), 1'($urandom_range(1)), 3'($urandom_range(7)));
        do_update();
        check_counts();
        do_update();
        check_counts();
        // Interrupt: sticky status, masking, write-one clear
        rd_chk({`IDX_STATUS, 2'b00}, {30'h0, exp_st}, 1'b0, "status");
        wr_chk({`IDX_ENABLE, 2'b00}, 32'h0, 1'b0);
        @(negedge clk_i);
        check_flag("masked irq", 1'b0, irq);
        wr_chk({`IDX_CLEAR, 2'b00}, 32'h3, 1'b0);
        exp_st = '0;
        rd_chk({`IDX_STATUS, 2'b00}, 32'h0, 1'b0, "cleared status");
        wr_chk({`IDX_ENABLE, 2'b00}, 32'h3, 1'b0);
        // Every mode, the illegal code too, with counting and holding selected, and sync loss set at random
        for (int m = 0; m < 4; m++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                @(posedge clk_i);
                frame_mode <= modes[m];
                sync_lost <= 1'($urandom_range(1));
                wr_chk({`IDX_CTRL, 2'b00}, 32'(c), 1'b0);
                ctrl_count = 1'(c);
                repeat (8)
                    send_frame(1'($urandom_range(1)), 1'b0, 3'($urandom_range(7)));
                do_update();
                check_counts();
                rd_chk({`IDX_STATUS, 2'b00}, {30'h0, exp_st}, 1'b0, "status");
                wr_chk({`IDX_CLEAR, 2'b00}, 32'h3, 1'b0);
                exp_st = '0;
            end
        end
        tally_and_finish();
    end

endmodule : tb_top
